// ### verilog/mpio_params.svh
/*
  constants for the port pin block: status and drive-select offsets,
  valid-bit masks and reset values. assumes byte-wide control space.
*/
`ifndef MPIO_PARAMS_SVH
`define MPIO_PARAMS_SVH

`define MPIO_OFF_DRV_A   8'h08
`define MPIO_OFF_DRV_B   8'h09
`define MPIO_OFF_DRV_C   8'h16
`define MPIO_OFF_DRV_D   8'h17
`define MPIO_OFF_OE_A    8'h0c
`define MPIO_OFF_OE_B    8'h0d
`define MPIO_OFF_OE_C    8'h1a
`define MPIO_OFF_OE_D    8'h1b
`define MPIO_OFF_DIR_A   8'h20
`define MPIO_OFF_DIR_B   8'h21
`define MPIO_OFF_DIR_C   8'h22
`define MPIO_OFF_DIR_D   8'h23
`define MPIO_OFF_DOUT_A  8'h24
`define MPIO_OFF_DOUT_B  8'h25
`define MPIO_OFF_DOUT_C  8'h26
`define MPIO_OFF_DOUT_D  8'h27
`define MPIO_OFF_MODE_A  8'h28
`define MPIO_OFF_MODE_B  8'h29
`define MPIO_OFF_FUNC    8'h2a
`define MPIO_OFF_PIN_A   8'h2c
`define MPIO_OFF_PIN_B   8'h2d
`define MPIO_OFF_PIN_C   8'h2e
`define MPIO_OFF_PIN_D   8'h2f

`define MPIO_MASK_C      8'h9c
`define MPIO_MASK_D      8'h06
`define MPIO_DRV_RST     8'h00
`define MPIO_ZERO8       8'h00

// function-register bit positions
`define MPIO_FN_STATUS6  0
`define MPIO_FN_CLKIN    1
`define MPIO_FN_CSI      2
`define MPIO_FN_BACKUP   3

`endif

// ### verilog/mpio_pkg.sv
/*
  types for the port pin block. assumes mpio_params.svh for numbers.
*/
package mpio_pkg;
  // output source of ports a and b
  typedef enum logic [2:0] {
    MPIO_MODE_MCU,
    MPIO_MODE_LOGIC_OUT,
    MPIO_MODE_LOGIC_IN,
    MPIO_MODE_ADDR_OUT,
    MPIO_MODE_PERIPH
  } mpio_mode_e;

  typedef logic [7:0] mpio_byte_t;

  typedef struct packed {
    mpio_byte_t drv_a, drv_b, drv_c, drv_d;
    mpio_byte_t dir_a, dir_b, dir_c, dir_d;
    mpio_byte_t dout_a, dout_b, dout_c, dout_d;
    mpio_mode_e mode_a, mode_b;
    logic [3:0] func;
    mpio_byte_t oe_a, oe_b, oe_c, oe_d;
    mpio_byte_t pad_a, pad_b, pad_c, pad_d;
    mpio_byte_t pin_a, pin_b, pin_c, pin_d;
    mpio_byte_t rdata;
    logic       standby;
    logic       omc_clk;
  } mpio_state_s;
endpackage : mpio_pkg

// ### verilog/mpio_port.sv
/*
  port pin block: four ports with drivers, enable status registers,
  drive select, dedicated functions on ports c and d.
  assumes a byte register port with one-cycle read data, and that
  logic-array, latched address and peripheral sources arrive as inputs.
*/
`timescale 1ns/1ps
`include "mpio_params.svh"

module mpio_port (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] logic_out_a_i,
  input  wire logic [7:0] logic_oe_a_i,
  input  wire logic [7:0] cell_ab_b_i,
  input  wire logic [7:0] cell_bc_b_i,
  input  wire logic [7:0] cell_sel_b_i,
  input  wire logic [7:0] logic_oe_b_i,
  input  wire logic [7:0] logic_out_c_i,
  input  wire logic [7:0] logic_oe_c_i,
  input  wire logic [1:0] ext_select_i,
  input  wire logic [1:0] ext_select_oe_i,
  input  wire logic [7:0] addr_latch_i,
  input  wire logic [7:0] periph_data_i,
  input  wire logic       periph_sel_i,
  input  wire logic       periph_rd_i,
  input  wire logic       flash_ready_i,
  input  wire logic       sram_on_backup_i,
  input  wire logic [7:0] pad_a_i,
  input  wire logic [7:0] pad_b_i,
  input  wire logic [7:0] pad_c_i,
  input  wire logic [7:0] pad_d_i,
  output logic      [7:0] pad_a_o,
  output logic      [7:0] pad_a_oe_n_o,
  output logic      [7:0] pad_a_alt_o,
  output logic      [7:0] pad_b_o,
  output logic      [7:0] pad_b_oe_n_o,
  output logic      [7:0] pad_b_alt_o,
  output logic      [7:0] pad_c_o,
  output logic      [7:0] pad_c_oe_n_o,
  output logic      [7:0] pad_c_alt_o,
  output logic      [7:0] pad_d_o,
  output logic      [7:0] pad_d_oe_n_o,
  output logic      [7:0] pad_d_alt_o,
  output logic      [7:0] logic_in_a_o,
  output logic      [7:0] logic_in_b_o,
  output logic      [7:0] logic_in_c_o,
  output logic      [7:0] logic_in_d_o,
  output logic            omc_clk_o,
  output logic            mem_standby_o
);

  mpio_pkg::mpio_state_s s_q;
  mpio_pkg::mpio_state_s s_d;

  // drive-select writes keep only pins that offer an alternate drive
  function automatic logic [7:0] keep_bits(input logic [7:0] v, input logic [7:0] m);
    keep_bits = v & m;
  endfunction : keep_bits

  // mode field decode; unknown codes fall back to mcu io
  function automatic mpio_pkg::mpio_mode_e to_mode(input logic [2:0] v, input logic per_ok);
    case (v)
      3'h1: to_mode = mpio_pkg::MPIO_MODE_LOGIC_OUT;
      3'h2: to_mode = mpio_pkg::MPIO_MODE_LOGIC_IN;
      3'h3: to_mode = mpio_pkg::MPIO_MODE_ADDR_OUT;
      3'h4: to_mode = per_ok ? mpio_pkg::MPIO_MODE_PERIPH : mpio_pkg::MPIO_MODE_MCU;
      default: to_mode = mpio_pkg::MPIO_MODE_MCU;
    endcase
  endfunction : to_mode

  logic [7:0] oe_a, oe_b, oe_c, oe_d;
  logic [7:0] dat_a, dat_b, dat_c, dat_d;

  // final driver enable and data per pin, from the selected source
  always_comb begin
    case (s_q.mode_a)
      mpio_pkg::MPIO_MODE_LOGIC_OUT: begin
        oe_a  = logic_oe_a_i;
        dat_a = logic_out_a_i;
      end
      mpio_pkg::MPIO_MODE_LOGIC_IN: begin
        oe_a  = `MPIO_ZERO8;
        dat_a = `MPIO_ZERO8;
      end
      mpio_pkg::MPIO_MODE_ADDR_OUT: begin
        oe_a  = 8'hff;
        dat_a = addr_latch_i;
      end
      mpio_pkg::MPIO_MODE_PERIPH: begin
        // repeater drives outward only on a selected read cycle
        oe_a  = {8{periph_sel_i & periph_rd_i}};
        dat_a = periph_data_i;
      end
      default: begin
        oe_a  = s_q.dir_a;
        dat_a = s_q.dout_a;
      end
    endcase
    case (s_q.mode_b)
      mpio_pkg::MPIO_MODE_LOGIC_OUT: begin
        oe_b  = logic_oe_b_i;
        dat_b = (cell_ab_b_i & ~cell_sel_b_i) | (cell_bc_b_i & cell_sel_b_i);
      end
      mpio_pkg::MPIO_MODE_LOGIC_IN: begin
        oe_b  = `MPIO_ZERO8;
        dat_b = `MPIO_ZERO8;
      end
      mpio_pkg::MPIO_MODE_ADDR_OUT: begin
        oe_b  = 8'hff;
        dat_b = addr_latch_i;
      end
      default: begin
        oe_b  = s_q.dir_b;
        dat_b = s_q.dout_b;
      end
    endcase
    // port c: per-pin direction or logic term, test pins never here
    oe_c  = (s_q.dir_c | logic_oe_c_i) & `MPIO_MASK_C;
    dat_c = (s_q.dout_c & ~logic_oe_c_i) | (logic_out_c_i & logic_oe_c_i);
    if (s_q.func[`MPIO_FN_STATUS6]) begin
      // pins 3 and 4 taken together as status outputs
      oe_c[3]  = 1'b1;
      oe_c[4]  = 1'b1;
      dat_c[3] = flash_ready_i;
      dat_c[4] = sram_on_backup_i;
    end
    if (s_q.func[`MPIO_FN_BACKUP]) begin
      oe_c[2] = 1'b0; // pin 2 is the battery supply input
    end
    oe_d  = (s_q.dir_d | {5'h00, ext_select_oe_i, 1'b0}) & `MPIO_MASK_D;
    dat_d = (s_q.dout_d & ~{5'h00, ext_select_oe_i, 1'b0}) | {5'h00, ext_select_i, 1'b0};
    if (s_q.func[`MPIO_FN_CLKIN]) begin
      oe_d[1] = 1'b0;
    end
    if (s_q.func[`MPIO_FN_CSI]) begin
      oe_d[2] = 1'b0;
    end
  end

  // register writes, reads and pin staging in one next-state block
  always_comb begin
    s_d = s_q;
    s_d.oe_a  = oe_a;
    s_d.oe_b  = oe_b;
    s_d.oe_c  = oe_c;
    s_d.oe_d  = oe_d;
    s_d.pad_a = dat_a;
    s_d.pad_b = dat_b;
    s_d.pad_c = dat_c;
    s_d.pad_d = dat_d;
    // inputs of pins in output mode still show the pad level
    s_d.pin_a = pad_a_i;
    s_d.pin_b = pad_b_i;
    s_d.pin_c = pad_c_i & `MPIO_MASK_C;
    s_d.pin_d = pad_d_i & `MPIO_MASK_D;
    s_d.omc_clk = s_q.func[`MPIO_FN_CLKIN] & pad_d_i[1];
    s_d.standby = s_q.func[`MPIO_FN_CSI] & pad_d_i[2];
    if (wr_i) begin
      case (addr_i)
        `MPIO_OFF_DRV_A:  s_d.drv_a = wdata_i;
        `MPIO_OFF_DRV_B:  s_d.drv_b = wdata_i;
        `MPIO_OFF_DRV_C:  s_d.drv_c = keep_bits(wdata_i, `MPIO_MASK_C);
        `MPIO_OFF_DRV_D:  s_d.drv_d = keep_bits(wdata_i, `MPIO_MASK_D);
        `MPIO_OFF_DIR_A:  s_d.dir_a = wdata_i;
        `MPIO_OFF_DIR_B:  s_d.dir_b = wdata_i;
        `MPIO_OFF_DIR_C:  s_d.dir_c = keep_bits(wdata_i, `MPIO_MASK_C);
        `MPIO_OFF_DIR_D:  s_d.dir_d = keep_bits(wdata_i, `MPIO_MASK_D);
        `MPIO_OFF_DOUT_A: s_d.dout_a = wdata_i;
        `MPIO_OFF_DOUT_B: s_d.dout_b = wdata_i;
        `MPIO_OFF_DOUT_C: s_d.dout_c = keep_bits(wdata_i, `MPIO_MASK_C);
        `MPIO_OFF_DOUT_D: s_d.dout_d = keep_bits(wdata_i, `MPIO_MASK_D);
        `MPIO_OFF_MODE_A: s_d.mode_a = to_mode(wdata_i[2:0], 1'b1);
        `MPIO_OFF_MODE_B: s_d.mode_b = to_mode(wdata_i[2:0], 1'b0);
        `MPIO_OFF_FUNC:   s_d.func = wdata_i[3:0];
        default: ; // status registers ignore writes
      endcase
    end
    s_d.rdata = `MPIO_ZERO8;
    if (rd_i) begin
      case (addr_i)
        `MPIO_OFF_OE_A:   s_d.rdata = s_q.oe_a;
        `MPIO_OFF_OE_B:   s_d.rdata = s_q.oe_b;
        `MPIO_OFF_OE_C:   s_d.rdata = s_q.oe_c & `MPIO_MASK_C;
        `MPIO_OFF_OE_D:   s_d.rdata = s_q.oe_d & `MPIO_MASK_D;
        `MPIO_OFF_DRV_A:  s_d.rdata = s_q.drv_a;
        `MPIO_OFF_DRV_B:  s_d.rdata = s_q.drv_b;
        `MPIO_OFF_DRV_C:  s_d.rdata = s_q.drv_c;
        `MPIO_OFF_DRV_D:  s_d.rdata = s_q.drv_d;
        `MPIO_OFF_DIR_A:  s_d.rdata = s_q.dir_a;
        `MPIO_OFF_DIR_B:  s_d.rdata = s_q.dir_b;
        `MPIO_OFF_DIR_C:  s_d.rdata = s_q.dir_c;
        `MPIO_OFF_DIR_D:  s_d.rdata = s_q.dir_d;
        `MPIO_OFF_DOUT_A: s_d.rdata = s_q.dout_a;
        `MPIO_OFF_DOUT_B: s_d.rdata = s_q.dout_b;
        `MPIO_OFF_DOUT_C: s_d.rdata = s_q.dout_c;
        `MPIO_OFF_DOUT_D: s_d.rdata = s_q.dout_d;
        `MPIO_OFF_MODE_A: s_d.rdata = {5'h00, s_q.mode_a};
        `MPIO_OFF_MODE_B: s_d.rdata = {5'h00, s_q.mode_b};
        `MPIO_OFF_FUNC:   s_d.rdata = {4'h0, s_q.func};
        `MPIO_OFF_PIN_A:  s_d.rdata = s_q.pin_a;
        `MPIO_OFF_PIN_B:  s_d.rdata = s_q.pin_b;
        `MPIO_OFF_PIN_C:  s_d.rdata = s_q.pin_c;
        `MPIO_OFF_PIN_D:  s_d.rdata = s_q.pin_d;
        default:          s_d.rdata = `MPIO_ZERO8;
      endcase
    end
  end

  // single state register; everything returns to push-pull inputs
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
      s_q.drv_a <= `MPIO_DRV_RST;
      s_q.drv_b <= `MPIO_DRV_RST;
      s_q.drv_c <= `MPIO_DRV_RST;
      s_q.drv_d <= `MPIO_DRV_RST;
      s_q.mode_a <= mpio_pkg::MPIO_MODE_MCU;
      s_q.mode_b <= mpio_pkg::MPIO_MODE_MCU;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; enables are active low
  assign rdata_o       = s_q.rdata;
  assign pad_a_o       = s_q.pad_a;
  assign pad_b_o       = s_q.pad_b;
  assign pad_c_o       = s_q.pad_c;
  assign pad_d_o       = s_q.pad_d;
  assign pad_a_oe_n_o  = ~s_q.oe_a;
  assign pad_b_oe_n_o  = ~s_q.oe_b;
  assign pad_c_oe_n_o  = ~s_q.oe_c;
  assign pad_d_oe_n_o  = ~s_q.oe_d;
  assign pad_a_alt_o   = s_q.drv_a;
  assign pad_b_alt_o   = s_q.drv_b;
  assign pad_c_alt_o   = s_q.drv_c;
  assign pad_d_alt_o   = s_q.drv_d;
  assign logic_in_a_o  = s_q.pin_a;
  assign logic_in_b_o  = s_q.pin_b;
  assign logic_in_c_o  = s_q.pin_c;
  assign logic_in_d_o  = s_q.pin_d;
  assign omc_clk_o     = s_q.omc_clk;
  assign mem_standby_o = s_q.standby;

  // status read: one cycle after read, value of enable in read cycle
  sequence rd_stat_a;
    rd_i && addr_i == `MPIO_OFF_OE_A;
  endsequence

  a_oe_a_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_stat_a |=> rdata_o == ~$past(pad_a_oe_n_o)) else $error("port a status mismatch");
  a_oe_b_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == `MPIO_OFF_OE_B |=> rdata_o == ~$past(pad_b_oe_n_o))
    else $error("port b status mismatch");
  a_oe_c_na: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == `MPIO_OFF_OE_C |=> (rdata_o & 8'h63) == 8'h00)
    else $error("port c na bits set");
  a_oe_d_na: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == `MPIO_OFF_OE_D |=> (rdata_o & 8'hf9) == 8'h00)
    else $error("port d na bits set");
  a_test_pins_off: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pad_c_oe_n_o & 8'h63) == 8'h63) else $error("test pin driven");
  a_status_pair: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_STATUS6] ##1 s_q.func[`MPIO_FN_STATUS6]
    |-> !pad_c_oe_n_o[3] && !pad_c_oe_n_o[4] && pad_c_o[3] == $past(flash_ready_i))
    else $error("status pair not driven");
  a_csi_standby: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_CSI] && pad_d_i[2] && !wr_i |=> mem_standby_o)
    else $error("standby not forced");
  a_drv_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    !(wr_i && addr_i == `MPIO_OFF_DRV_A) |=> $stable(pad_a_alt_o))
    else $error("drive select changed");
  a_status_ro: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == `MPIO_OFF_OE_A |=> $stable(s_q.dir_a) && $stable(s_q.mode_a))
    else $error("status write had effect");

  // drive select writes reach the pad drive type next cycle
  a_drv_a_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == `MPIO_OFF_DRV_A |=> pad_a_alt_o == $past(wdata_i))
    else $error("port a drive select wrong");
  a_drv_b_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == `MPIO_OFF_DRV_B |=> pad_b_alt_o == $past(wdata_i))
    else $error("port b drive select wrong");
  a_drv_c_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == `MPIO_OFF_DRV_C |=> pad_c_alt_o == ($past(wdata_i) & `MPIO_MASK_C))
    else $error("port c drive select wrong");
  a_drv_d_write: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_i && addr_i == `MPIO_OFF_DRV_D |=> pad_d_alt_o == ($past(wdata_i) & `MPIO_MASK_D))
    else $error("port d drive select wrong");

  // port a pads follow the source of the mode in force one cycle before
  a_mode_a_mcu: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_a == mpio_pkg::MPIO_MODE_MCU |=> pad_a_oe_n_o == ~$past(s_q.dir_a))
    else $error("port a direction not followed");
  a_mode_a_logic: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_a == mpio_pkg::MPIO_MODE_LOGIC_OUT |=> pad_a_oe_n_o == ~$past(logic_oe_a_i)
    && pad_a_o == $past(logic_out_a_i)) else $error("port a logic output wrong");
  a_mode_a_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_a == mpio_pkg::MPIO_MODE_ADDR_OUT |=> pad_a_oe_n_o == 8'h00
    && pad_a_o == $past(addr_latch_i)) else $error("port a address output wrong");
  a_mode_a_periph: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_a == mpio_pkg::MPIO_MODE_PERIPH |=> pad_a_o == $past(periph_data_i)
    && pad_a_oe_n_o == ~{8{$past(periph_sel_i) & $past(periph_rd_i)}})
    else $error("port a repeater wrong");
  a_mode_a_in: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_a == mpio_pkg::MPIO_MODE_LOGIC_IN |=> pad_a_oe_n_o == 8'hff)
    else $error("port a input mode driven");

  // port b pads follow the mode source; cell mode takes each pin from the group its select names
  a_mode_b_mcu: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_b == mpio_pkg::MPIO_MODE_MCU |=> pad_b_oe_n_o == ~$past(s_q.dir_b))
    else $error("port b direction not followed");
  a_mode_b_cells: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_b == mpio_pkg::MPIO_MODE_LOGIC_OUT |=> pad_b_oe_n_o == ~$past(logic_oe_b_i)
    && pad_b_o == (($past(cell_bc_b_i) & $past(cell_sel_b_i))
    | ($past(cell_ab_b_i) & ~$past(cell_sel_b_i)))) else $error("port b cell output wrong");
  a_mode_b_addr: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_b == mpio_pkg::MPIO_MODE_ADDR_OUT |=> pad_b_oe_n_o == 8'h00
    && pad_b_o == $past(addr_latch_i)) else $error("port b address output wrong");
  a_mode_b_in: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.mode_b == mpio_pkg::MPIO_MODE_LOGIC_IN |=> pad_b_oe_n_o == 8'hff)
    else $error("port b input mode driven");

  // port c dedicated functions and enable status
  a_status_data: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_STATUS6] |=> pad_c_o[3] == $past(flash_ready_i)
    && pad_c_o[4] == $past(sram_on_backup_i)) else $error("status pins wrong");
  a_backup_input: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_BACKUP] |=> pad_c_oe_n_o[2]) else $error("backup pin driven");
  a_oe_c_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == `MPIO_OFF_OE_C |=> rdata_o == (~$past(pad_c_oe_n_o) & `MPIO_MASK_C))
    else $error("port c status mismatch");

  // port d pins taken as inputs by their dedicated functions
  a_clkin_input: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_CLKIN] |=> pad_d_oe_n_o[1] && omc_clk_o == $past(pad_d_i[1]))
    else $error("clock input pin wrong");
  a_csi_input: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    s_q.func[`MPIO_FN_CSI] |=> pad_d_oe_n_o[2]) else $error("select input pin driven");
  a_port_d_na: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    (pad_d_oe_n_o & 8'hf9) == 8'hf9) else $error("port d absent pin driven");
  a_oe_d_read: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    rd_i && addr_i == `MPIO_OFF_OE_D |=> rdata_o == (~$past(pad_d_oe_n_o) & `MPIO_MASK_D))
    else $error("port d status mismatch");
endmodule : mpio_port

// ### tb/mpio_pad_model.sv
/*
  model of the outside circuitry on one byte of port pins: weak pull-ups,
  an optional external source, and open-drain release of a driven high.
  assumes the block's drive data, active-low enable and drive-select bytes.
*/
`timescale 1ns/1ps

module mpio_pad_model #(
  parameter logic [7:0] OD_MASK = 8'h00
) (
  input  wire logic [7:0] drv_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] alt_i,
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] level_o
);
  logic [7:0] od;
  logic [7:0] released;

  // alt bits outside the mask only change slew, so they drive as usual
  assign od       = alt_i & OD_MASK;
  // enable off means high impedance; open drain lets go of a high
  assign released = oe_n_i | (od & drv_i);
  // released pins read the outside source, or the pull-up when none
  assign level_o  = (~released & drv_i) | (released & ((ext_en_i & ext_i) | ~ext_en_i));
endmodule : mpio_pad_model

// ### tb/mpio_port_bench.sv
/*
  self-checking bench for the port pin block: register port, status and
  drive-select registers, port modes and dedicated functions.
  assumes the pad model on all four ports and one-cycle registered outputs.
*/
`timescale 1ns/1ps
`include "mpio_params.svh"

module mpio_port_bench;
  logic       mclk_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, lo_a = 8'h00, loe_a = 8'h00;
  logic       wr_i = 1'b0, rd_i = 1'b0, psel = 1'b0, prd = 1'b0, fready = 1'b0, bkup = 1'b0;
  logic [7:0] c_ab = 8'h00, c_bc = 8'h00, c_sel = 8'h00, loe_b = 8'h00, lo_c = 8'h00;
  logic [7:0] loe_c = 8'h00, alat = 8'h00, pdat = 8'h00;
  logic [1:0] esel = 2'h0, esel_oe = 2'h0;
  logic [7:0] ext_a = 8'h00, ext_d = 8'h00, een_a = 8'h00, een_d = 8'h00;
  logic [7:0] ext_b = 8'h00, ext_c = 8'h00, een_b = 8'h00, een_c = 8'h00;
  logic [7:0] pi_a, pi_b, pi_c, pi_d, po_a, po_b, po_c, po_d;
  logic [7:0] on_a, on_b, on_c, on_d, al_a, al_b, al_c, al_d, rdata_o;
  logic [7:0] li_a, li_b, li_c, li_d;
  logic       omc_clk_o, mem_standby_o;
  int         n_fail = 0;
  int         cmp_count = 0;

  mpio_port i_mpio_port (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .logic_out_a_i(lo_a),
    .logic_oe_a_i(loe_a), .cell_ab_b_i(c_ab), .cell_bc_b_i(c_bc), .cell_sel_b_i(c_sel),
    .logic_oe_b_i(loe_b), .logic_out_c_i(lo_c), .logic_oe_c_i(loe_c),
    .ext_select_i(esel), .ext_select_oe_i(esel_oe), .addr_latch_i(alat),
    .periph_data_i(pdat), .periph_sel_i(psel), .periph_rd_i(prd),
    .flash_ready_i(fready), .sram_on_backup_i(bkup), .pad_a_i(pi_a), .pad_b_i(pi_b),
    .pad_c_i(pi_c), .pad_d_i(pi_d), .pad_a_o(po_a), .pad_a_oe_n_o(on_a),
    .pad_a_alt_o(al_a), .pad_b_o(po_b), .pad_b_oe_n_o(on_b), .pad_b_alt_o(al_b),
    .pad_c_o(po_c), .pad_c_oe_n_o(on_c), .pad_c_alt_o(al_c), .pad_d_o(po_d),
    .pad_d_oe_n_o(on_d), .pad_d_alt_o(al_d), .logic_in_a_o(li_a), .logic_in_b_o(li_b),
    .logic_in_c_o(li_c), .logic_in_d_o(li_d), .omc_clk_o(omc_clk_o),
    .mem_standby_o(mem_standby_o));

  // one pad model per port; only a and b upper nibbles and c 9c can open-drain
  mpio_pad_model #(.OD_MASK(8'hf0)) i_mpio_pad_model_a (.drv_i(po_a), .oe_n_i(on_a),
    .alt_i(al_a), .ext_i(ext_a), .ext_en_i(een_a), .level_o(pi_a));
  mpio_pad_model #(.OD_MASK(8'hf0)) i_mpio_pad_model_b (.drv_i(po_b), .oe_n_i(on_b),
    .alt_i(al_b), .ext_i(ext_b), .ext_en_i(een_b), .level_o(pi_b));
  mpio_pad_model #(.OD_MASK(8'h9c)) i_mpio_pad_model_c (.drv_i(po_c), .oe_n_i(on_c),
    .alt_i(al_c), .ext_i(ext_c), .ext_en_i(een_c), .level_o(pi_c));
  mpio_pad_model #(.OD_MASK(8'h00)) i_mpio_pad_model_d (.drv_i(po_d), .oe_n_i(on_d),
    .alt_i(al_d), .ext_i(ext_d), .ext_en_i(een_d), .level_o(pi_d));

  // 200 mhz clock
  always #2.5 mclk_i = ~mclk_i;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bus write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask : wr

  // bus read; data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask : rd_chk

  // lets registered outputs and the status lag settle
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc

  task automatic t_reset();
    check(on_a & on_b & on_c & on_d, 8'hff);
    check({7'h00, mem_standby_o}, 8'h00);
    rd_chk(`MPIO_OFF_OE_A, 8'h00);
    rd_chk(`MPIO_OFF_DRV_A, `MPIO_DRV_RST);
    rd_chk(`MPIO_OFF_DRV_C, `MPIO_DRV_RST);
    rd_chk(`MPIO_OFF_DRV_D, `MPIO_DRV_RST);
    rd_chk(8'h40, 8'h00);
  endtask : t_reset

  task automatic t_status();
    wr(`MPIO_OFF_DIR_A, 8'ha5);
    wr(`MPIO_OFF_DIR_B, 8'h3c);
    wr(`MPIO_OFF_DIR_C, 8'hff);
    wr(`MPIO_OFF_DIR_D, 8'hff);
    wr(`MPIO_OFF_OE_A, 8'hff);
    cyc(2);
    check(on_a, 8'h5a);
    check(on_c & 8'h63, 8'h63);
    rd_chk(`MPIO_OFF_OE_A, 8'ha5);
    rd_chk(`MPIO_OFF_OE_B, 8'h3c);
    rd_chk(`MPIO_OFF_OE_C, 8'h9c);
    rd_chk(`MPIO_OFF_OE_D, 8'h06);
  endtask : t_status

  task automatic t_drive();
    wr(`MPIO_OFF_DRV_A, 8'hf0);
    wr(`MPIO_OFF_DRV_B, 8'hff);
    wr(`MPIO_OFF_DRV_C, 8'hff);
    wr(`MPIO_OFF_DRV_D, 8'hff);
    wr(`MPIO_OFF_DOUT_A, 8'h0f);
    cyc(3);
    check(al_a, 8'hf0);
    check(al_b, 8'hff);
    check(li_a & 8'ha5, 8'h05);
    rd_chk(`MPIO_OFF_DRV_C, 8'h9c);
    rd_chk(`MPIO_OFF_DRV_D, 8'h06);
    check(al_d, 8'h06);
    // open drain on b5 lets go of its high, the outside pulls it low
    wr(`MPIO_OFF_DOUT_B, 8'hff);
    een_b <= 8'h20;
    cyc(3);
    rd_chk(`MPIO_OFF_PIN_B, 8'hdf);
    wr(`MPIO_OFF_DIR_A, 8'h00);
    ext_a <= 8'h5a;
    een_a <= 8'hff;
    cyc(3);
    rd_chk(`MPIO_OFF_PIN_A, 8'h5a);
    check(li_a, 8'h5a);
  endtask : t_drive

  task automatic t_modes();
    een_a <= 8'h00;
    lo_a  <= 8'hc3;
    loe_a <= 8'h0f;
    wr(`MPIO_OFF_MODE_A, 8'h01);
    cyc(3);
    check(on_a, 8'hf0);
    check(po_a, 8'hc3);
    rd_chk(`MPIO_OFF_OE_A, 8'h0f);
    alat <= 8'h96;
    wr(`MPIO_OFF_MODE_A, 8'h03);
    cyc(3);
    check(po_a, 8'h96);
    pdat <= 8'h3c;
    psel <= 1'b1;
    prd  <= 1'b1;
    wr(`MPIO_OFF_MODE_A, 8'h04);
    cyc(3);
    check(po_a, 8'h3c);
    rd_chk(`MPIO_OFF_OE_A, 8'hff);
    psel <= 1'b0;
    cyc(3);
    rd_chk(`MPIO_OFF_OE_A, 8'h00);
    c_ab  <= 8'hff;
    c_sel <= 8'h0f;
    c_bc  <= 8'h05;
    loe_b <= 8'hff;
    wr(`MPIO_OFF_MODE_B, 8'h01);
    cyc(3);
    check(po_b, 8'hf5);
    rd_chk(`MPIO_OFF_OE_B, 8'hff);
    wr(`MPIO_OFF_MODE_B, 8'h03);
    cyc(3);
    check(po_b, 8'h96);
    check(on_b, 8'h00);
    wr(`MPIO_OFF_MODE_B, 8'h04);
    rd_chk(`MPIO_OFF_MODE_B, 8'h00);
    wr(`MPIO_OFF_MODE_A, 8'h02);
    cyc(3);
    check(on_a, 8'hff);
    rd_chk(`MPIO_OFF_OE_A, 8'h00);
  endtask : t_modes

  task automatic t_port_cd();
    wr(`MPIO_OFF_DIR_C, 8'h00);
    wr(`MPIO_OFF_DIR_D, 8'h00);
    lo_c    <= 8'hff;
    loe_c   <= 8'hff;
    esel    <= 2'h2;
    esel_oe <= 2'h3;
    cyc(3);
    rd_chk(`MPIO_OFF_OE_C, 8'h9c);
    rd_chk(`MPIO_OFF_OE_D, 8'h06);
    check(po_d & 8'h06, 8'h04);
    loe_c   <= 8'h00;
    esel_oe <= 2'h0;
    een_d   <= 8'h06;
    ext_d   <= 8'h04;
    wr(`MPIO_OFF_FUNC, 8'h04);
    cyc(3);
    check({7'h00, mem_standby_o}, 8'h01);
    ext_d <= 8'h02;
    wr(`MPIO_OFF_FUNC, 8'h02);
    cyc(3);
    check({6'h00, omc_clk_o, mem_standby_o}, 8'h02);
    fready <= 1'b1;
    wr(`MPIO_OFF_FUNC, 8'h01);
    cyc(3);
    check(po_c & 8'h18, 8'h08);
    check(on_c & 8'h18, 8'h00);
    fready <= 1'b0;
    bkup   <= 1'b1;
    cyc(3);
    check(po_c & 8'h18, 8'h10);
    rd_chk(`MPIO_OFF_OE_C, 8'h18);
    // battery input on pin 2 overrides its direction bit
    wr(`MPIO_OFF_DIR_C, 8'h04);
    een_c <= 8'h04;
    wr(`MPIO_OFF_FUNC, 8'h09);
    cyc(3);
    rd_chk(`MPIO_OFF_OE_C, 8'h18);
    rd_chk(`MPIO_OFF_PIN_C, 8'h90);
  endtask : t_port_cd

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  // main sequence after five reset cycles
  initial begin
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    #1;
    t_reset();
    t_status();
    t_drive();
    t_modes();
    t_port_cd();
    conclude();
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    n_fail++;
    conclude();
  end
endmodule : mpio_port_bench
